// file: tct_pkg.sv
// Shared constants and types for the three channel interval timer.
// Assumes a 32-bit AXI4-Lite register port with an 8-bit byte address.
package tct_pkg;

	// ----------------------------------------------------------------
	// Register map (byte addresses)
	// ----------------------------------------------------------------
	localparam int         TCT_AW       = 8;
	localparam logic [7:0] TCT_CTL0     = 8'h00;  // +4 per channel
	localparam logic [7:0] TCT_CNT0     = 8'h10;  // +4 per channel
	localparam logic [7:0] TCT_CMD      = 8'h20;
	localparam logic [7:0] TCT_LAT0     = 8'h30;  // +4 per channel
	localparam logic [7:0] TCT_ROUTE    = 8'h40;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int TCT_CTL_BCD      = 3;   // Mode sits in bits 2:0
	localparam int TCT_CMD_TRIG     = 4;   // Latch bits 2:0, triggers 6:4
	localparam int TCT_ST_OUT       = 4;   // Latch-valid 2:0, outputs 6:4
	localparam int TCT_RT_STRIDE    = 8;   // Per general channel in ROUTE
	localparam int TCT_RT_GSEL      = 4;   // Out enables 2:0, gate select 5:4

	// ----------------------------------------------------------------
	// Values after reset
	// ----------------------------------------------------------------
	localparam logic [3:0]  TCT_CTL_RST   = 4'h0;
	localparam logic [15:0] TCT_ROUTE_RST = 16'h2020;  // Gates forced on, outputs off
	localparam logic [15:0] TCT_CNT_RST   = 16'h0000;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	localparam logic [1:0] TCT_RESP_OKAY   = 2'b00;
	localparam logic [1:0] TCT_RESP_SLVERR = 2'b10;

	typedef enum logic [2:0] {
		TCT_M_TC      = 3'b000,
		TCT_M_ONESHOT = 3'b001,
		TCT_M_RATE    = 3'b010,
		TCT_M_SQUARE  = 3'b011,
		TCT_M_SWSTB   = 3'b100,
		TCT_M_HWSTB   = 3'b101,
		TCT_M_EVENT   = 3'b110
	} tct_mode_t;

	typedef enum logic [1:0] {
		TCT_G_TERM = 2'b00,
		TCT_G_PIO  = 2'b01,
		TCT_G_ON   = 2'b10
	} tct_gsel_t;

	typedef struct packed {
		logic [15:0] count;
		logic [15:0] reload;
		logic        out;
		logic        run;
	} tct_chan_t;

	typedef struct packed {
		logic            tick;
		logic            gate;
		logic            gate_rise;
		logic            ctl_we;
		logic            load_we;
		logic            sw_trig;
		logic [2:0]      mode;
		logic            bcd;
		logic [15:0]     load_val;
	} tct_chan_in_t;

endpackage

// file: tct_channel.sv
// One 16-bit down counter with its seven counting functions.
// Assumes tick, gate and gate_rise are already synchronised to aclk.
`timescale 1ns/1ps
module tct_channel
	import tct_pkg::*;
(
	// Clock and reset
	input  wire logic         aclk,
	input  wire logic         aresetn,
	// Control from the register file
	input  wire tct_chan_in_t ci,
	// Channel state
	output tct_chan_t         st
);

	tct_chan_t q, n;
	tct_mode_t mode;

	assign mode = tct_mode_t'(ci.mode);
	assign st   = q;

	// ----------------------------------------------------------------
	// Arithmetic helpers
	// ----------------------------------------------------------------
	function automatic logic [15:0] dec(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic        bw;
		r  = v;
		bw = 1'b1;
		if (!bcd) begin
			r = v - 16'h0001;
		end else begin
			for (int d = 0; d < 4; d++) begin
				if (bw) begin
					if (v[d*4 +: 4] == 4'h0) begin
						r[d*4 +: 4] = 4'h9;
					end else begin
						r[d*4 +: 4] = v[d*4 +: 4] - 4'h1;
						bw          = 1'b0;
					end
				end
			end
		end
		return r;
	endfunction

	// Halving digit by digit keeps square-wave phases exact in BCD
	function automatic logic [15:0] half(input logic [15:0] v, input logic bcd);
		logic [15:0] r;
		logic        odd;
		logic [3:0]  dg;
		r   = {1'b0, v[15:1]};
		odd = 1'b0;
		if (bcd) begin
			for (int d = 3; d >= 0; d--) begin
				dg           = v[d*4 +: 4];
				r[d*4 +: 4]  = {1'b0, dg[3:1]} + (odd ? 4'h5 : 4'h0);
				odd          = dg[0];
			end
		end
		// A loaded zero stands for the full range, whose half is not v/2
		if (v == 16'h0000) begin
			r = bcd ? 16'h5000 : 16'h8000;
		end
		return r;
	endfunction

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	logic        trig;
	logic [15:0] nxt;
	logic        at_one;

	always_comb begin
		n      = q;
		trig   = ci.gate_rise | ci.sw_trig;
		nxt    = dec(q.count, ci.bcd);
		at_one = (q.count == 16'h0001);
		if (ci.ctl_we) begin
			n.run = 1'b0;
			n.out = !(mode == TCT_M_TC || mode == TCT_M_EVENT);
		end else if (ci.load_we) begin
			n.reload = ci.load_val;
			n.count  = ci.load_val;
			n.run    = !(mode == TCT_M_ONESHOT || mode == TCT_M_HWSTB);
			n.out    = !(mode == TCT_M_TC || mode == TCT_M_EVENT);
		end else if (trig && (mode == TCT_M_ONESHOT || mode == TCT_M_HWSTB)) begin
			n.count = q.reload;
			n.run   = 1'b1;
			n.out   = (mode != TCT_M_ONESHOT);
		end else if (ci.tick && q.run) begin
			unique case (mode)
				TCT_M_TC, TCT_M_EVENT: begin
					if (ci.gate) begin
						n.count = nxt;
						if (at_one) begin
							n.out = 1'b1;
						end
					end
				end
				TCT_M_ONESHOT: begin
					n.count = nxt;
					if (at_one) begin
						n.out = 1'b1;
						n.run = 1'b0;
					end
				end
				TCT_M_RATE: begin
					if (ci.gate) begin
						n.out   = !at_one;
						n.count = at_one ? q.reload : nxt;
					end
				end
				TCT_M_SQUARE: begin
					if (ci.gate) begin
						if (at_one) begin
							n.count = q.reload;
							n.out   = 1'b1;
						end else begin
							n.count = nxt;
							if (nxt == half(q.reload, ci.bcd)) begin
								n.out = 1'b0;
							end
						end
					end
				end
				TCT_M_SWSTB, TCT_M_HWSTB: begin
					if (mode == TCT_M_HWSTB || ci.gate) begin
						if (!q.out) begin
							n.out = 1'b1;
							n.run = 1'b0;
						end else begin
							n.count = nxt;
							n.out   = !at_one;
						end
					end
				end
				default: begin
					n.run = 1'b0;
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q <= '{count: TCT_CNT_RST, reload: TCT_CNT_RST, out: 1'b1, run: 1'b0};
		end else begin
			q <= n;
		end
	end

endmodule

// file: tct_timer.sv
// Three channel 16-bit interval timer / event counter with AXI4-Lite registers.
// Assumes counting clocks and gate sources arrive as pins outside the aclk domain.
//
// What this block does
// - Three independent 16-bit channels each work as interval timer or event counter.
// - Each channel counts in binary or in BCD, chosen per channel.
// - Channel two drives the serial baud clock; channels zero and one are general use.
// - General channels route outputs and pick gate sources by static configuration.
// - Software picks one of seven counting functions per channel by writing its control register.
// - The running count of each channel can be read at any time without stopping it.
// - A latch command captures a running count so software reads a stable value.
// - In terminal-count function the output rises as an interrupt at terminal count.
// - In rate function the output is low one counting clock out of every N.
// - In square-wave function the output is high for half the count, low for the rest.
// - The one-shot goes low on trigger or command, high at terminal count, retriggerable.
`timescale 1ns/1ps
module tct_timer
	import tct_pkg::*;
(
	// Clock and reset
	input  wire logic              aclk,
	input  wire logic              aresetn,
	// AXI4-Lite write address and data
	input  wire logic [TCT_AW-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read
	input  wire logic [TCT_AW-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Counting clocks and gate sources (pins)
	input  wire logic [2:0]        cnt_clk_pin,
	input  wire logic [1:0]        gate_term_pin,
	input  wire logic [1:0]        gate_pio_pin,
	// Routed outputs of the general channels
	output logic [1:0]             irq_req,
	output logic [1:0]             pio_drv,
	output logic [1:0]             periph_in,
	// Serial baud clock
	output logic                   baud_clk
);

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             awready;
		logic             bvalid;
		logic [1:0]       bresp;
		logic             arready;
		logic             rvalid;
		logic [1:0]       rresp;
		logic [31:0]      rdata;
		logic [2:0][3:0]  ctl;
		logic [15:0]      route;
		logic [2:0][15:0] lat;
		logic [2:0]       latv;
		logic [2:0]       clk_s1;
		logic [2:0]       clk_s2;
		logic [2:0]       clk_s3;
		logic [1:0]       gt_s1;
		logic [1:0]       gt_s2;
		logic [1:0]       gp_s1;
		logic [1:0]       gp_s2;
		logic [2:0]       gate_prev;
		logic [1:0]       irq;
		logic [1:0]       pio;
		logic [1:0]       per;
		logic             baud;
	} tct_top_t;

	tct_top_t     q, n;
	tct_chan_in_t ci   [3];
	tct_chan_t    cs   [3];
	logic [2:0]   gate_lvl;
	logic         wr_en;
	logic         wr_go;
	logic         rd_go;
	logic         wr_full;

	// Write happens in the cycle the address/data handshake completes
	assign wr_en   = q.awready;
	assign wr_go   = s_axi_awvalid & s_axi_wvalid & !q.awready & !q.bvalid;
	assign rd_go   = s_axi_arvalid & !q.arready & !q.rvalid;
	assign wr_full = (s_axi_wstrb[1:0] == 2'b11);

	// ----------------------------------------------------------------
	// Channels
	// ----------------------------------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ch
			logic [1:0] gsel;
			logic       ctl_hit;
			if (gi < 2) begin : g_gen
				assign gsel = q.route[gi*TCT_RT_STRIDE + TCT_RT_GSEL +: 2];
				assign gate_lvl[gi] = (gsel == TCT_G_TERM) ? q.gt_s2[gi] :
				                      (gsel == TCT_G_PIO)  ? q.gp_s2[gi] : 1'b1;
			end else begin : g_baud
				assign gsel         = TCT_G_ON;
				assign gate_lvl[gi] = 1'b1;
			end
			assign ci[gi].tick      = q.clk_s2[gi] & !q.clk_s3[gi];
			assign ci[gi].gate      = gate_lvl[gi];
			assign ci[gi].gate_rise = gate_lvl[gi] & !q.gate_prev[gi];
			assign ctl_hit          = wr_en & s_axi_wstrb[0]
			                        & (s_axi_awaddr == TCT_CTL0 + 8'(gi * 4));
			assign ci[gi].ctl_we    = ctl_hit;
			assign ci[gi].load_we   = wr_en & wr_full
			                        & (s_axi_awaddr == TCT_CNT0 + 8'(gi * 4));
			assign ci[gi].sw_trig   = wr_en & s_axi_wstrb[0] & (s_axi_awaddr == TCT_CMD)
			                        & s_axi_wdata[TCT_CMD_TRIG + gi];
			// A control write sets the idle output from the new mode, not the old one
			assign ci[gi].mode      = ctl_hit ? s_axi_wdata[2:0] : q.ctl[gi][2:0];
			assign ci[gi].bcd       = q.ctl[gi][TCT_CTL_BCD];
			assign ci[gi].load_val  = s_axi_wdata[15:0];

			tct_channel u_ch (
				.aclk    (aclk),
				.aresetn (aresetn),
				.ci      (ci[gi]),
				.st      (cs[gi])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// Register file and routing
	// ----------------------------------------------------------------
	logic [7:0] ra;
	logic [7:0] wa;

	always_comb begin
		n  = q;
		ra = s_axi_araddr;
		wa = s_axi_awaddr;

		// Pins pass two flops before anything looks at them
		n.clk_s1    = cnt_clk_pin;
		n.clk_s2    = q.clk_s1;
		n.clk_s3    = q.clk_s2;
		n.gt_s1     = gate_term_pin;
		n.gt_s2     = q.gt_s1;
		n.gp_s1     = gate_pio_pin;
		n.gp_s2     = q.gp_s1;
		n.gate_prev = gate_lvl;

		// Write channel
		n.awready = wr_go;
		if (q.bvalid && s_axi_bready) begin
			n.bvalid = 1'b0;
		end
		if (wr_en) begin
			n.bvalid = 1'b1;
			n.bresp  = TCT_RESP_OKAY;
			unique case (wa)
				TCT_CTL0, TCT_CTL0 + 8'h04, TCT_CTL0 + 8'h08: begin
					if (s_axi_wstrb[0]) begin
						n.ctl[wa[3:2]] = s_axi_wdata[3:0];
					end
				end
				TCT_CNT0, TCT_CNT0 + 8'h04, TCT_CNT0 + 8'h08: begin
					if (!wr_full) begin
						n.bresp = TCT_RESP_SLVERR;   // Half a count would corrupt the load
					end
				end
				TCT_CMD: ;
				TCT_ROUTE: begin
					if (s_axi_wstrb[0]) begin
						n.route[7:0] = s_axi_wdata[7:0];
					end
					if (s_axi_wstrb[1]) begin
						n.route[15:8] = s_axi_wdata[15:8];
					end
				end
				default: begin
					n.bresp = TCT_RESP_SLVERR;
				end
			endcase
		end

		// Read channel
		n.arready = rd_go;
		if (q.rvalid && s_axi_rready) begin
			n.rvalid = 1'b0;
		end
		if (q.arready) begin
			n.rvalid = 1'b1;
			n.rresp  = TCT_RESP_OKAY;
			n.rdata  = 32'h0000_0000;
			unique case (ra)
				TCT_CTL0, TCT_CTL0 + 8'h04, TCT_CTL0 + 8'h08: begin
					n.rdata[3:0] = q.ctl[ra[3:2]];
				end
				TCT_CNT0, TCT_CNT0 + 8'h04, TCT_CNT0 + 8'h08: begin
					n.rdata[15:0] = cs[ra[3:2]].count;
				end
				TCT_CMD: begin
					n.rdata[2:0] = q.latv;
					n.rdata[TCT_ST_OUT +: 3] = {cs[2].out, cs[1].out, cs[0].out};
				end
				TCT_LAT0, TCT_LAT0 + 8'h04, TCT_LAT0 + 8'h08: begin
					n.rdata[15:0]     = q.lat[ra[3:2]];
					n.latv[ra[3:2]]   = 1'b0;
				end
				TCT_ROUTE: begin
					n.rdata[15:0] = q.route;
				end
				default: begin
					n.rresp = TCT_RESP_SLVERR;
				end
			endcase
		end

		// Latch command wins over a same-cycle read of the latched value
		if (wr_en && s_axi_wstrb[0] && wa == TCT_CMD) begin
			for (int i = 0; i < 3; i++) begin
				if (s_axi_wdata[i]) begin
					n.lat[i]  = cs[i].count;
					n.latv[i] = 1'b1;
				end
			end
		end

		// Static output routing, one flop before the pins
		for (int i = 0; i < 2; i++) begin
			n.irq[i] = cs[i].out & q.route[i*TCT_RT_STRIDE + 0];
			n.pio[i] = cs[i].out & q.route[i*TCT_RT_STRIDE + 1];
			n.per[i] = cs[i].out & q.route[i*TCT_RT_STRIDE + 2];
		end
		n.baud = cs[2].out;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			q       <= '0;
			q.ctl   <= {3{TCT_CTL_RST}};
			q.route <= TCT_ROUTE_RST;
		end else begin
			q <= n;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign s_axi_awready = q.awready;
	assign s_axi_wready  = q.awready;
	assign s_axi_bvalid  = q.bvalid;
	assign s_axi_bresp   = q.bresp;
	assign s_axi_arready = q.arready;
	assign s_axi_rvalid  = q.rvalid;
	assign s_axi_rresp   = q.rresp;
	assign s_axi_rdata   = q.rdata;
	assign irq_req       = q.irq;
	assign pio_drv       = q.pio;
	assign periph_in     = q.per;
	assign baud_clk      = q.baud;

endmodule

// file: tct_cnt_src.sv
// Counting clock source for the three channel pins of the timer.
// Assumes aclk at 250 MHz; a pulse is 4 aclk high then at least 4 low.
`timescale 1ns/1ps
module tct_cnt_src (
	// Clock and reset
	input  wire logic       aclk,
	input  wire logic       aresetn,
	// Which channels get the next pulse
	input  wire logic [2:0] en,
	// Pins and pulse start marker
	output logic [2:0]      cnt_clk,
	output logic            rise
);
	logic [2:0] ph_q;
	logic [2:0] en_q;

	// Enables are taken only as a pulse starts, so no pulse is ever cut short
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ph_q <= 3'h0;
			en_q <= 3'h0;
		end else begin
			ph_q <= ph_q + 3'h1;
			if (ph_q == 3'h3) begin
				en_q <= en;
			end
		end
	end

	// Pins stand low between pulses
	assign cnt_clk = en_q & {3{ph_q[2]}};
	assign rise    = (ph_q == 3'h4) && (|en_q);
endmodule

// file: tct_timer_sva.sv
// Register port checker for the interval timer.
// Assumes it is bound to tct_timer and sees only its ports.
`timescale 1ns/1ps
module tct_timer_sva
	import tct_pkg::*;
(
	// Clock and reset
	input wire logic        aclk,
	input wire logic        aresetn,
	// Write channels
	input wire logic        s_axi_awvalid,
	input wire logic        s_axi_awready,
	input wire logic        s_axi_wvalid,
	input wire logic        s_axi_wready,
	input wire logic        s_axi_bvalid,
	input wire logic        s_axi_bready,
	// Read channels
	input wire logic        s_axi_arvalid,
	input wire logic        s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0]  s_axi_rresp,
	input wire logic        s_axi_rvalid,
	input wire logic        s_axi_rready
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	property p_wpair; s_axi_awready |-> s_axi_wready; endproperty
	a_wpair: assert property (p_wpair) else $error("write readies split");
	property p_wtake; s_axi_awvalid && s_axi_wvalid && !s_axi_bvalid && !s_axi_awready
		|=> s_axi_awready; endproperty
	a_wtake: assert property (p_wtake) else $error("write not taken");
	property p_bans; s_axi_awready |=> s_axi_bvalid && !s_axi_awready; endproperty
	a_bans: assert property (p_bans) else $error("write answer late");
	property p_bhold; s_axi_bvalid |-> !s_axi_awready; endproperty
	a_bhold: assert property (p_bhold) else $error("write taken while answer pending");
	property p_bdone; s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid; endproperty
	a_bdone: assert property (p_bdone) else $error("write answer stuck");
	property p_rtake; s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_arready;
	endproperty
	a_rtake: assert property (p_rtake) else $error("read not taken");
	property p_rans; s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
	a_rans: assert property (p_rans) else $error("read answer late");
	property p_rhold; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_rhold: assert property (p_rhold) else $error("read taken while answer pending");
	property p_rerr; s_axi_rvalid && (s_axi_rresp == TCT_RESP_SLVERR)
		|-> (s_axi_rdata == 32'h0000_0000); endproperty
	a_rerr: assert property (p_rerr) else $error("refused read carries data");
	property p_rdone; s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid; endproperty
	a_rdone: assert property (p_rdone) else $error("read answer stuck");
endmodule

bind tct_timer tct_timer_sva i_sva (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
	.s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
	.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

// file: tct_timer_test.sv
// Self-checking bench for the interval timer.
// Assumes tct_cnt_src drives the counting pins; bench acts as register master.
`timescale 1ns/1ps
module tct_timer_test
	import tct_pkg::*;
;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp, gate_term_pin = 2'h0, irq_req, pio_drv, periph_in;
	logic [1:0] gate_pio_pin = 2'h0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, baud_clk;
	logic [2:0] cnt_clk_pin, cnt_en = 3'h0;
	logic src_rise;
	logic [31:0] d;
	logic [1:0] r;
	int mismatches = 0, n_compared = 0, cyc = 0, hi;
	logic [7:0] ra[8] = '{8'h00, 8'h04, 8'h08, 8'h10, 8'h18, 8'h20, 8'h40, 8'h24};
	logic [31:0] rv[8] = '{32'(TCT_CTL_RST), 32'(TCT_CTL_RST), 32'(TCT_CTL_RST),
		32'(TCT_CNT_RST), 32'(TCT_CNT_RST), 32'h0000_0070, 32'(TCT_ROUTE_RST), 32'h0};

	always #2 aclk = ~aclk;

	tct_timer i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
		.s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cnt_clk_pin, .gate_term_pin,
		.gate_pio_pin, .irq_req, .pio_drv, .periph_in, .baud_clk);
	tct_cnt_src i_src (.aclk, .aresetn, .en(cnt_en), .cnt_clk(cnt_clk_pin), .rise(src_rise));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic test_done;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		n_compared++;
		if (s !== e) begin
			mismatches++;
			$display("CHECK FAILED at %0t: saw %h want %h", $time, s, e);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] v,
		input logic [3:0] s = 4'hf, input logic [1:0] e = TCT_RESP_OKAY);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(negedge aclk); while (s_axi_awready !== 1'b1);
		@(posedge aclk);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
		chk(32'(s_axi_bresp), 32'(e));
		@(posedge aclk);
		s_axi_bready <= 1'b0;
		@(negedge aclk);
	endtask
	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(negedge aclk); while (s_axi_arready !== 1'b1);
		@(posedge aclk);
		s_axi_arvalid <= 1'b0;
		do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
		d = s_axi_rdata;
		r = s_axi_rresp;
		@(posedge aclk);
		s_axi_rready <= 1'b0;
	endtask
	task automatic rck(input logic [7:0] a, input logic [31:0] e);
		rd(a);
		chk(d, e);
		chk(32'(r), 32'(TCT_RESP_OKAY));
	endtask
	// One counting clock pulse to the channels in m; returns with outputs settled
	task automatic tk(input logic [2:0] m);
		@(posedge aclk);
		cnt_en <= m;
		do @(negedge aclk); while (src_rise !== 1'b1);
		repeat (6) @(negedge aclk);
		@(posedge aclk);
		cnt_en <= 3'h0;
		@(negedge aclk);
	endtask

	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			mismatches++;
			test_done();
		end
	end

	// ----------------------------------------------------------------
	// Sequence
	// ----------------------------------------------------------------
	initial begin
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(ra[i]);
			chk(d, rv[i]);
			chk(32'(r), (i == 7) ? 32'(TCT_RESP_SLVERR) : 32'(TCT_RESP_OKAY));
		end
		wr(8'h00, 32'h2);
		wr(8'h10, 32'h3);
		wr(8'h04, 32'h3);
		wr(8'h14, 32'h4);
		wr(8'h40, 32'h0000_2221);
		hi = 0;
		for (int i = 0; i < 12; i++) begin
			tk(3'h3);
			chk(32'(irq_req[0]), (i % 3 == 2) ? 32'h0 : 32'h1);
			chk({30'h0, irq_req[1], periph_in[1]}, 32'h0);
			hi += pio_drv[1];
		end
		chk(hi, 32'h6);
		rck(8'h10, 32'h3);
		wr(8'h20, 32'h1);
		tk(3'h1);
		rck(8'h10, 32'h2);
		rck(8'h14, 32'h4);
		rd(8'h20);
		chk(32'(d[0]), 32'h1);
		rck(8'h30, 32'h3);
		rd(8'h20);
		chk(32'(d[0]), 32'h0);
		wr(8'h08, 32'h8);
		wr(8'h18, 32'h10);
		tk(3'h4);
		rck(8'h18, 32'h9);
		chk(32'(baud_clk), 32'h0);
		wr(8'h00, 32'h0);
		chk(32'(irq_req[0]), 32'h0);
		wr(8'h10, 32'h2);
		chk(32'(irq_req[0]), 32'h0);
		tk(3'h1);
		chk(32'(irq_req[0]), 32'h0);
		tk(3'h1);
		chk(32'(irq_req[0]), 32'h1);
		wr(8'h10, 32'h5, 4'h1, TCT_RESP_SLVERR);
		wr(8'h4c, 32'h5, 4'hf, TCT_RESP_SLVERR);
		rck(8'h10, 32'h0);
		wr(8'h40, 32'h0000_2421);
		wr(8'h04, 32'h1);
		wr(8'h14, 32'h2);
		chk(32'(periph_in[1]), 32'h1);
		wr(8'h20, 32'h20);
		tk(3'h2);
		chk(32'(periph_in[1]), 32'h0);
		wr(8'h20, 32'h20);
		tk(3'h2);
		chk(32'(periph_in[1]), 32'h0);
		tk(3'h2);
		chk(32'(periph_in[1]), 32'h1);
		for (int m = 0; m < 7; m++) begin
			wr(8'h08, 32'(m));
			rck(8'h08, 32'(m));
		end
		wr(8'h40, 32'h0000_2401);
		wr(8'h00, 32'h2);
		wr(8'h10, 32'h5);
		tk(3'h1);
		rck(8'h10, 32'h5);
		@(posedge aclk);
		gate_term_pin <= 2'h1;
		tk(3'h1);
		rck(8'h10, 32'h4);
		wr(8'h04, 32'h4);
		wr(8'h14, 32'h2);
		for (int i = 0; i < 3; i++) begin
			tk(3'h2);
			chk(32'(periph_in[1]), (i == 1) ? 32'h0 : 32'h1);
		end
		wr(8'h40, 32'h0000_1401);
		wr(8'h04, 32'h5);
		wr(8'h14, 32'h2);
		tk(3'h2);
		rck(8'h14, 32'h2);
		@(posedge aclk);
		gate_pio_pin <= 2'h2;
		for (int i = 0; i < 3; i++) begin
			tk(3'h2);
			chk(32'(periph_in[1]), (i == 1) ? 32'h0 : 32'h1);
		end
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk(32'(irq_req), 32'h0);
		rck(8'h40, 32'(TCT_ROUTE_RST));
		test_done();
	end
endmodule
